// file: rtl/cascaded_tick_timer.sv
// Tick and wake down-counters with a calibration timer, behind an APB slave.
// Assumes the tick clock, calibration clock and debug halt arrive as pins
// slower than clk/4; all three are synchronised here, and the two clocks are edge detected.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps

// Summary of operation
// R1 - Two independent 16-bit reloadable down-counters.
// R2 - Tick counter steps on tick clock, raises underflow.
// R3 - Wake counter steps on tick underflow events.
// R4 - Enable bit set to one starts counter.
// R5 - Software writes reload only after enabling.
// R6 - Clearing enable stops; counters stopped after reset.
// R7 - Enabled, non-zero reload: decrement each tick edge.
// R8 - Tick underflow high one tick clock cycle.
// R9 - Next tick edge after zero reloads start value.
// R10 - Wake counter decrements once per tick underflow.
// R11 - Wake counter reloads on next event after zero.
// R12 - Calibration timer increments each calibration clock edge.
// R13 - At all-ones, set overflow flag, wrap to zero.
// R14 - Tick underflow captures count, raises capture interrupt.
// R15 - Optional clear and restart after each capture.
// R16 - Capture after two equal post-edge samples.
// R17 - Tick clock below half calibration clock.
// R18 - Debug breakpoint can stop tick and wake counters.
// R19 - Capture trigger edge is selectable.
// R20 - Disable stops at once, forces count zero.
// R21 - Zero reload: no counting, no underflow.
// R22 - Overflow flag sticky until software clears it.
module cascaded_tick_timer (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tick_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Asynchronous pins.
  input wire logic tick_clock,
  input wire logic calibration_clock,
  input wire logic debug_halt,
  // Event outputs.
  output logic tick_underflow_irq,
  output logic wake_underflow_irq,
  output logic calibration_capture_irq
);

  tick_timer_pkg::top_state_t s;
  tick_timer_pkg::top_state_t next_s;

  down_counter_if tick_if ();
  down_counter_if wake_if ();

  logic tick_edge;
  logic cal_edge;
  logic freeze;
  logic wr;
  logic rd_setup;
  logic old_lvl;
  logic new_lvl;
  logic rise_seen;
  logic fall_seen;
  logic capture;
  logic ovf_set;
  logic ovf_clr;
  logic [31:0] rdata;
  logic rerr;

  // Only the second synchroniser stage feeds the edge detectors.
  assign tick_edge = s.tick_sync[1] & ~s.tick_prev;
  assign cal_edge = s.cal_sync[1] & ~s.cal_prev;
  assign freeze = s.dbg_sync[1] & s.dbg_stop; // R18

  // Zero-wait slave: read data is prepared in the setup cycle.
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;

  assign tick_if.enable = s.tick_en; // R4
  assign tick_if.freeze = freeze;
  assign tick_if.count_event = tick_edge; // R2
  assign tick_if.reload = s.tick_reload;
  assign wake_if.enable = s.wake_en; // R4
  assign wake_if.freeze = freeze;
  assign wake_if.count_event = tick_if.zero_pulse; // R3 R10
  assign wake_if.reload = s.wake_reload;

  down_counter u_tick_counter ( // R1
    .clk(clk),
    .rst_b(rst_b),
    .dc(tick_if.cnt)
  );

  down_counter u_wake_counter ( // R1
    .clk(clk),
    .rst_b(rst_b),
    .dc(wake_if.cnt)
  );

  // Register read mux; unmapped offsets answer zero with an error.
  always_comb begin
    rdata = 32'h0000_0000;
    rerr = 1'b0;
    unique case (paddr)
      tick_timer_pkg::TICK_CTRL_OFS: rdata[tick_timer_pkg::ENABLE_BIT] = s.tick_en;
      tick_timer_pkg::TICK_RELOAD_OFS: rdata[15:0] = s.tick_reload;
      tick_timer_pkg::TICK_COUNT_OFS: rdata[15:0] = tick_if.count;
      tick_timer_pkg::WAKE_CTRL_OFS: rdata[tick_timer_pkg::ENABLE_BIT] = s.wake_en;
      tick_timer_pkg::WAKE_RELOAD_OFS: rdata[15:0] = s.wake_reload;
      tick_timer_pkg::WAKE_COUNT_OFS: rdata[15:0] = wake_if.count;
      tick_timer_pkg::CAL_CTRL_OFS: begin
        rdata[tick_timer_pkg::CAL_ENABLE_BIT] = s.cal_en;
        rdata[tick_timer_pkg::CAL_RESTART_BIT] = s.cal_restart;
        rdata[tick_timer_pkg::CAL_EDGE_LSB +: 2] = s.cal_edge_sel;
        rdata[tick_timer_pkg::DEBUG_STOP_BIT] = s.dbg_stop;
      end
      tick_timer_pkg::CAL_COUNT_OFS: rdata[15:0] = s.cal_count;
      tick_timer_pkg::CAL_CAPTURE_OFS: rdata[15:0] = s.cal_capture;
      tick_timer_pkg::CAL_STATUS_OFS: rdata[tick_timer_pkg::CAL_OVF_BIT] = s.cal_ovf;
      default: rerr = 1'b1;
    endcase
  end

  // Capture edge detection on samples taken at calibration clock edges.
  always_comb begin
    old_lvl = s.cal_hist[1];
    new_lvl = s.cal_hist[0];
    rise_seen = ~s.cal_hist[2] & s.cal_hist[1] & s.cal_hist[0]; // R16
    fall_seen = s.cal_hist[2] & ~s.cal_hist[1] & ~s.cal_hist[0]; // R16
    unique case (s.cal_edge_sel)
      tick_timer_pkg::EDGE_RISING: capture = rise_seen; // R19
      tick_timer_pkg::EDGE_FALLING: capture = fall_seen; // R19
      tick_timer_pkg::EDGE_BOTH: capture = rise_seen | fall_seen; // R19
      tick_timer_pkg::EDGE_NONE: capture = 1'b0;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.tick_sync = {s.tick_sync[0], tick_clock};
    next_s.cal_sync = {s.cal_sync[0], calibration_clock};
    next_s.dbg_sync = {s.dbg_sync[0], debug_halt};
    next_s.tick_prev = s.tick_sync[1];
    next_s.cal_prev = s.cal_sync[1];
    next_s.cal_irq = 1'b0;
    ovf_set = 1'b0;
    ovf_clr = 1'b0;

    // A disabled counter keeps its reload register cleared.
    if (!s.tick_en) begin
      next_s.tick_reload = tick_timer_pkg::COUNT_RESET; // R6
    end
    if (!s.wake_en) begin
      next_s.wake_reload = tick_timer_pkg::COUNT_RESET; // R6
    end

    if (wr) begin
      unique case (paddr)
        tick_timer_pkg::TICK_CTRL_OFS: next_s.tick_en = pwdata[tick_timer_pkg::ENABLE_BIT]; // R4
        tick_timer_pkg::WAKE_CTRL_OFS: next_s.wake_en = pwdata[tick_timer_pkg::ENABLE_BIT]; // R4
        tick_timer_pkg::TICK_RELOAD_OFS: begin
          if (s.tick_en) begin
            next_s.tick_reload = pwdata[15:0]; // R5
          end
        end
        tick_timer_pkg::WAKE_RELOAD_OFS: begin
          if (s.wake_en) begin
            next_s.wake_reload = pwdata[15:0]; // R5
          end
        end
        tick_timer_pkg::CAL_CTRL_OFS: begin
          next_s.cal_en = pwdata[tick_timer_pkg::CAL_ENABLE_BIT];
          next_s.cal_restart = pwdata[tick_timer_pkg::CAL_RESTART_BIT]; // R15
          next_s.cal_edge_sel = tick_timer_pkg::edge_sel_t'(pwdata[tick_timer_pkg::CAL_EDGE_LSB +: 2]);
          next_s.dbg_stop = pwdata[tick_timer_pkg::DEBUG_STOP_BIT];
        end
        tick_timer_pkg::CAL_STATUS_OFS: ovf_clr = pwdata[tick_timer_pkg::CAL_OVF_BIT];
        default: begin
        end
      endcase
    end

    if (!s.cal_en) begin
      next_s.cal_count = tick_timer_pkg::COUNT_RESET;
      next_s.cal_hist = 3'h0;
    end else if (cal_edge) begin
      // The underflow line is only looked at on calibration clock edges.
      next_s.cal_hist = {s.cal_hist[1:0], tick_underflow_irq}; // R16 R17
      if (s.cal_count == tick_timer_pkg::COUNT_MAX) begin
        next_s.cal_count = tick_timer_pkg::COUNT_RESET; // R13
        ovf_set = 1'b1; // R13
      end else begin
        next_s.cal_count = s.cal_count + 16'h0001; // R12
      end
      if (capture) begin
        next_s.cal_capture = s.cal_count; // R14
        next_s.cal_irq = 1'b1; // R14
        if (s.cal_restart) begin
          next_s.cal_count = tick_timer_pkg::COUNT_RESET; // R15
        end
      end
    end

    // A wrap in the same cycle as a clear leaves the flag set.
    next_s.cal_ovf = (s.cal_ovf & ~ovf_clr) | ovf_set; // R22

    if (rd_setup) begin
      next_s.prdata = rdata;
      next_s.pslverr = rerr;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pready = 1'b1;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign tick_underflow_irq = tick_if.at_zero; // R8
  assign wake_underflow_irq = wake_if.at_zero; // R3
  assign calibration_capture_irq = s.cal_irq;

endmodule // cascaded_tick_timer

// file: common/tick_timer_pkg.sv
// Constants, register map and state types of the cascaded tick timer.
// Assumes a 32-bit APB slave with byte addresses and word-aligned registers.
package tick_timer_pkg;

  localparam int COUNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int SYNC_STAGES = 2;

  localparam logic [ADDR_W-1:0] TICK_CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] TICK_RELOAD_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] TICK_COUNT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] WAKE_CTRL_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] WAKE_RELOAD_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] WAKE_COUNT_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] CAL_CTRL_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] CAL_COUNT_OFS = 8'h1c;
  localparam logic [ADDR_W-1:0] CAL_CAPTURE_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] CAL_STATUS_OFS = 8'h24;

  // Counter control register field.
  localparam int ENABLE_BIT = 7;
  // Calibration control register fields.
  localparam int CAL_ENABLE_BIT = 0;
  localparam int CAL_RESTART_BIT = 1;
  localparam int CAL_EDGE_LSB = 2;
  localparam int DEBUG_STOP_BIT = 4;
  // Calibration status register field.
  localparam int CAL_OVF_BIT = 0;

  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hffff;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISING = 2'h1,
    EDGE_FALLING = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_sel_t;

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic at_zero;
    logic zero_pulse;
  } down_state_t;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] tick_sync;
    logic [SYNC_STAGES-1:0] cal_sync;
    logic [SYNC_STAGES-1:0] dbg_sync;
    logic tick_prev;
    logic cal_prev;
    logic tick_en;
    logic wake_en;
    logic [COUNT_W-1:0] tick_reload;
    logic [COUNT_W-1:0] wake_reload;
    logic cal_en;
    logic cal_restart;
    edge_sel_t cal_edge_sel;
    logic dbg_stop;
    logic [COUNT_W-1:0] cal_count;
    logic [COUNT_W-1:0] cal_capture;
    logic cal_ovf;
    logic [2:0] cal_hist;
    logic cal_irq;
    logic [31:0] prdata;
    logic pslverr;
  } top_state_t;

endpackage

// file: common/down_counter_if.sv
// Connection between the timer top and one reloadable down-counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface down_counter_if;
  logic enable;
  logic freeze;
  logic count_event;
  logic [tick_timer_pkg::COUNT_W-1:0] reload;
  logic [tick_timer_pkg::COUNT_W-1:0] count;
  logic at_zero;
  logic zero_pulse;

  modport ctl (output enable, output freeze, output count_event, output reload,
               input count, input at_zero, input zero_pulse);
  modport cnt (input enable, input freeze, input count_event, input reload,
               output count, output at_zero, output zero_pulse);
endinterface

// file: rtl/down_counter.sv
// One 16-bit reloadable down-counter stepped by count events.
// Assumes count_event is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
module down_counter (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Control and status towards the top.
  down_counter_if.cnt dc
);

  tick_timer_pkg::down_state_t s;
  tick_timer_pkg::down_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.zero_pulse = 1'b0;
    if (!dc.enable) begin
      next_s.count = tick_timer_pkg::COUNT_RESET; // R20
      next_s.at_zero = 1'b0; // R6
    end else if (dc.reload == tick_timer_pkg::COUNT_RESET) begin
      next_s.at_zero = 1'b0; // R21
    end else if (dc.count_event && !dc.freeze) begin // R18
      if (s.count == tick_timer_pkg::COUNT_RESET) begin
        next_s.count = dc.reload; // R9
        next_s.at_zero = 1'b0; // R11
      end else begin
        next_s.count = s.count - 16'h0001; // R7
        if (s.count == 16'h0001) begin
          next_s.at_zero = 1'b1; // R8
          next_s.zero_pulse = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dc.count = s.count;
  assign dc.at_zero = s.at_zero;
  assign dc.zero_pulse = s.zero_pulse;

endmodule // down_counter

// file: sim/cascaded_tick_timer_sva.sv
// Port assertions for the cascaded tick timer.
// Assumes one clk domain and slow tick and calibration pins.
`timescale 1ns/1ps
module cascaded_tick_timer_sva (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tick_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Pins and events.
  input wire logic tick_clock,
  input wire logic calibration_clock,
  input wire logic debug_halt,
  input wire logic tick_underflow_irq,
  input wire logic wake_underflow_irq,
  input wire logic calibration_capture_irq
);
  // Clocks since the tick event line last changed; saturates so a stale edge never looks fresh.
  logic [7:0] since;
  logic tick_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      since <= 8'hff;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_underflow_irq;
      since <= (tick_underflow_irq != tick_q) ? 8'h00 : since + {7'h00, since != 8'hff};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_tick_from_edge: assert property ($rose(tick_underflow_irq) |-> $past(tick_clock, 3))
    else $error("tick event without tick clock edge");
  a_tick_irq_stands: assert property ($rose(tick_underflow_irq) |=> tick_underflow_irq [*8])
    else $error("tick event shorter than a tick period");
  a_wake_follows_tick: assert property ($rose(wake_underflow_irq) |-> tick_underflow_irq)
    else $error("wake event without tick event");
  a_wake_irq_stands: assert property ($rose(wake_underflow_irq) |=> wake_underflow_irq [*8])
    else $error("wake event dropped early");
  a_cap_one_pulse: assert property (calibration_capture_irq |=> !calibration_capture_irq)
    else $error("capture event longer than one clock");
  a_cap_after_samples: assert property (calibration_capture_irq |-> since >= 8'h06 && since <= 8'h30)
    else $error("capture too soon or too late after tick edge");
  a_disable_clears: assert property ((psel && penable && pwrite && paddr == tick_timer_pkg::TICK_CTRL_OFS
    && !pwdata[7]) ##2 (psel && !penable && !pwrite && paddr == tick_timer_pkg::TICK_COUNT_OFS)
    |=> prdata == 32'h0)
    else $error("count not zero after disable");
  a_unmapped_err: assert property (psel && !penable && paddr == 8'h40 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule // cascaded_tick_timer_sva

bind cascaded_tick_timer cascaded_tick_timer_sva u_sva (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .tick_clock(tick_clock), .calibration_clock(calibration_clock), .debug_halt(debug_halt),
  .tick_underflow_irq(tick_underflow_irq), .wake_underflow_irq(wake_underflow_irq),
  .calibration_capture_irq(calibration_capture_irq));

// file: sim/cascaded_tick_timer_test.sv
// Self-checking bench for the cascaded tick timer.
// Assumes the bench alone drives APB and the pins; tick period 48 clk, calibration period 8 clk.
`timescale 1ns/1ps
module cascaded_tick_timer_test;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [tick_timer_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e, tick_clock, calibration_clock, debug_halt, tick_q, wake_q;
  logic tick_underflow_irq, wake_underflow_irq, calibration_capture_irq;
  logic [15:0] c [3];
  int fail_count, checks_done, tick_rises, wake_rises, caps, t;
  cascaded_tick_timer u_cascaded_tick_timer (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .tick_clock(tick_clock), .calibration_clock(calibration_clock), .debug_halt(debug_halt),
    .tick_underflow_irq(tick_underflow_irq), .wake_underflow_irq(wake_underflow_irq),
    .calibration_capture_irq(calibration_capture_irq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // The calibration clock runs free, well above twice the tick rate.
  initial begin
    calibration_clock = 1'b0;
    forever begin
      repeat (4) @(posedge clk);
      calibration_clock <= ~calibration_clock;
    end
  end
  always @(posedge clk) begin
    tick_q <= tick_underflow_irq;
    wake_q <= wake_underflow_irq;
    if (tick_underflow_irq === 1'b1 && tick_q !== 1'b1) tick_rises++;
    if (wake_underflow_irq === 1'b1 && wake_q !== 1'b1) wake_rises++;
    if (calibration_capture_irq === 1'b1) caps++;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for the answer.
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick_edges(input int n);
    repeat (n) begin
      @(posedge clk);
      tick_clock <= 1'b1;
      repeat (24) @(posedge clk);
      tick_clock <= 1'b0;
      repeat (23) @(posedge clk);
    end
  endtask
  task automatic t_reset;
    logic [7:0] ofs [6];
    ofs = '{8'h00, 8'h08, 8'h10, 8'h1c, 8'h20, 8'h24};
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      check("reset_value", r, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped_err", {31'h0, e}, 32'h1);
    apb(1'b1, tick_timer_pkg::TICK_RELOAD_OFS, 32'h2);
    apb(1'b0, tick_timer_pkg::TICK_RELOAD_OFS, 32'h0);
    check("reload_while_off", r, 32'h0);
  endtask
  task automatic t_cascade;
    apb(1'b1, tick_timer_pkg::TICK_CTRL_OFS, 32'h80);
    apb(1'b1, tick_timer_pkg::TICK_RELOAD_OFS, 32'h2);
    apb(1'b1, tick_timer_pkg::WAKE_CTRL_OFS, 32'h80);
    apb(1'b1, tick_timer_pkg::WAKE_RELOAD_OFS, 32'h2);
    tick_rises = 0;
    wake_rises = 0;
    tick_edges(9);
    check("tick_events", tick_rises, 32'h3);
    check("wake_events", wake_rises, 32'h1);
    apb(1'b0, tick_timer_pkg::TICK_RELOAD_OFS, 32'h0);
    check("tick_reload", r, 32'h2);
  endtask
  task automatic t_cal;
    // Enabled only after the tick event has fallen, so no start-up capture can happen.
    tick_edges(1);
    apb(1'b1, tick_timer_pkg::CAL_CTRL_OFS, 32'h5);
    // The capture is read during the third tick period, so tick edges stay exactly 48 clk apart.
    for (int i = 0; i < 2; i++) begin
      fork
        tick_edges(3);
        begin
          repeat (120) @(posedge clk);
          apb(1'b0, tick_timer_pkg::CAL_CAPTURE_OFS, 32'h0);
        end
      join
      c[i] = r[15:0];
    end
    // Three tick periods of 48 clk at 8 clk per calibration step.
    check("cal_interval", {16'h0, c[1] - c[0]}, 32'h12);
    apb(1'b1, tick_timer_pkg::CAL_CTRL_OFS, 32'h7);
    for (int i = 0; i < 3; i++) begin
      fork
        tick_edges(3);
        begin
          repeat (120) @(posedge clk);
          apb(1'b0, tick_timer_pkg::CAL_CAPTURE_OFS, 32'h0);
        end
      join
      c[i] = r[15:0];
    end
    check("cal_restart", {16'h0, c[2]}, {16'h0, c[1]});
    check("cal_restart_low", {31'h0, c[2] < 16'h0012}, 32'h1);
  endtask
  task automatic t_edges;
    int exp [4];
    exp = '{0, 2, 2, 4};
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, tick_timer_pkg::CAL_CTRL_OFS, 32'h1 | (s << 2));
      t = caps;
      tick_edges(6);
      repeat (24) @(posedge clk);
      check("edge_captures", caps - t, exp[s]);
    end
  endtask
  task automatic t_stop;
    apb(1'b1, tick_timer_pkg::CAL_CTRL_OFS, 32'h10);
    debug_halt <= 1'b1;
    t = tick_rises;
    tick_edges(6);
    check("debug_frozen", tick_rises - t, 32'h0);
    debug_halt <= 1'b0;
    apb(1'b1, tick_timer_pkg::TICK_CTRL_OFS, 32'h0);
    apb(1'b0, tick_timer_pkg::TICK_COUNT_OFS, 32'h0);
    check("count_after_off", r, 32'h0);
    apb(1'b1, tick_timer_pkg::TICK_CTRL_OFS, 32'h80);
    t = tick_rises;
    tick_edges(6);
    check("zero_reload_idle", tick_rises - t, 32'h0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    test_done();
  end
  initial begin
    {rst_b, psel, penable, pwrite, tick_clock, debug_halt} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_cascade();
    t_cal();
    t_edges();
    t_stop();
    test_done();
  end
endmodule // cascaded_tick_timer_test
